// File: verilog/bcsm_defs.svh
`ifndef BCSM_DEFS_SVH
`define BCSM_DEFS_SVH

// clock rate and timer width
`define BCSM_CLK_HZ 40000000
`define BCSM_TW 40
`define BCSM_TCNT_ONE 40'h00_0000_0001

// times in their own units (plain defaults, tune per product)
`define BCSM_SETTLE_MS 16
`define BCSM_TERM_QUALIFY_MS 30
`define BCSM_PREQUAL_S 1800
`define BCSM_FASTCHARGE_S 10800
`define BCSM_TOPOFF_S 600
`define BCSM_WATCHDOG_S 80

// register byte offsets
`define BCSM_AW 12
`define BCSM_OFS_CTRL 12'h000
`define BCSM_OFS_WDCLR 12'h004
`define BCSM_OFS_STATUS 12'h008

// control register fields and reset values
`define BCSM_CTRL_EN_BIT 0
`define BCSM_CTRL_PQ_BIT 1
`define BCSM_CTRL_WD_BIT 2
`define BCSM_RST_CHARGE_EN 1'b1
`define BCSM_RST_PREQUAL_EN 1'b1
`define BCSM_RST_WD_EN 1'b0

// watchdog clear field and its restart value
`define BCSM_WDCLR_MSB 1
`define BCSM_WDCLR_RESTART 2'h1

// status register fields
`define BCSM_STAT_CODE_LSB 0
`define BCSM_STAT_OK_BIT 4
`define BCSM_STAT_STATE_LSB 8
`define BCSM_STAT_WDEXP_BIT 12

// detail codes
`define BCSM_CODE_PRECHARGE 4'h0
`define BCSM_CODE_TRICKLE 4'h0
`define BCSM_CODE_FAST_CC 4'h1
`define BCSM_CODE_FAST_CV 4'h2
`define BCSM_CODE_TOPOFF 4'h3
`define BCSM_CODE_DONE 4'h4
`define BCSM_CODE_TIMER_FAULT 4'h6
`define BCSM_CODE_IDLE 4'h8
`define BCSM_CODE_THERMAL 4'hA
`define BCSM_CODE_WD_SUSPEND 4'hB
`define BCSM_CODE_RESET 4'h8

// current selection encodings
`define BCSM_ISEL_OFF 2'h0
`define BCSM_ISEL_PRECHARGE 2'h1
`define BCSM_ISEL_TRICKLE 2'h2
`define BCSM_ISEL_FAST 2'h3

`endif

// File: verilog/bcsm_pkg.sv
`include "bcsm_defs.svh"

package bcsm_pkg;

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0000,
      ST_PRECHARGE = 4'b0001,
      ST_TRICKLE = 4'b0010,
      ST_FAST_CC = 4'b0011,
      ST_FAST_CV = 4'b0100,
      ST_TOPOFF = 4'b0101,
      ST_DONE = 4'b0110,
      ST_TIMER_FAULT = 4'b0111,
      ST_WD_SUSPEND = 4'b1000,
      ST_THERMAL = 4'b1001
   } bcsm_state_t;

   typedef struct packed {
      bcsm_state_t state;
      logic charge_en;
      logic prequal_en;
      logic wd_en;
      logic wd_clear;
      logic [1:0] current_sel;
      logic charging;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } bcsm_main_t;

   typedef struct packed {
      logic [3:0] code;
      logic ok;
      logic irq;
   } bcsm_status_t;

   typedef struct packed {
      logic [`BCSM_TW-1:0] count;
      logic expired;
      logic hit;
   } bcsm_timer_t;

endpackage

// File: verilog/bcsm_timer.sv
`timescale 1ns/10ps
`default_nettype none
`include "bcsm_defs.svh"

module bcsm_timer (
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic i_clear,
   input wire logic [`BCSM_TW-1:0] i_limit,
   output logic o_expired,
   output logic o_hit,
   output logic [`BCSM_TW-1:0] o_count
);

   bcsm_pkg::bcsm_timer_t q;
   bcsm_pkg::bcsm_timer_t d;

   // counts up to the limit and then holds; hit marks the single expiry cycle
   always_comb begin
      d = q;
      d.hit = 1'b0;
      if (i_clear) begin
         d.count = '0;
         d.expired = 1'b0;
      end else if (!q.expired) begin
         d.count = q.count + `BCSM_TCNT_ONE;
         if (d.count >= i_limit) begin
            d.expired = 1'b1;
            d.hit = 1'b1;
         end
      end
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign o_expired = q.expired;
   assign o_hit = q.hit;
   assign o_count = q.count;

endmodule

`default_nettype wire

// File: verilog/bcsm_status.sv
`timescale 1ns/10ps
`default_nettype none
`include "bcsm_defs.svh"

module bcsm_status (
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic i_update,
   input wire logic i_force,
   input wire logic i_force_irq,
   input wire logic [3:0] i_code,
   input wire logic i_ok,
   output logic [3:0] o_code,
   output logic o_ok,
   output logic o_irq
);

   bcsm_pkg::bcsm_status_t q;
   bcsm_pkg::bcsm_status_t d;

   // event fires on a change of the ok flag, or whenever the force irq input is set with a force
   always_comb begin
      d = q;
      d.irq = 1'b0;
      if (i_update || i_force) begin
         d.code = i_code;
         d.ok = i_ok;
         d.irq = (i_ok != q.ok) || i_force_irq;
      end
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         q <= '{code: `BCSM_CODE_RESET, ok: 1'b0, irq: 1'b0};
      end else begin
         q <= d;
      end
   end

   assign o_code = q.code;
   assign o_ok = q.ok;
   assign o_irq = q.irq;

endmodule

`default_nettype wire

// File: verilog/bcsm_charger.sv
// Notes on behaviour
// - disable or bad input forces idle, except thermal
// - idle settles to code 0x08, ok set
// - idle: zero current, all timers but settle held cleared
// - leave idle, other than to thermal, only with valid input and enable
// - precharge below threshold, settles code 0x00, ok
// - precharge to trickle, or fault on prequal timeout
// - trickle band settles code 0x00, ok set
// - prequal enable picks trickle or bypass to fast
// - trickle to fast cc, or fault on timeout
// - fast cc settles code 0x01, ok set
// - cc to cv at regulation, fault on timeout
// - cv settles code 0x02, ok set
// - cv to topoff after low current qualify time
// - topoff only from cv, settles code 0x03
// - topoff duration elapsed moves to done
// - topoff back to cc below restart level
// - expired enabled watchdog suspends any charging state
// - timer fault: immediate event, ok cleared, 0x06
// - done settles: ok cleared, code 0x04
`timescale 1ns/10ps
`default_nettype none
`include "bcsm_defs.svh"

module bcsm_charger #(
   parameter logic [`BCSM_TW-1:0] SETTLE_CYCLES =
      `BCSM_TW'(64'(`BCSM_SETTLE_MS) * 64'(`BCSM_CLK_HZ) / 64'd1000),
   parameter logic [`BCSM_TW-1:0] TERM_QUALIFY_CYCLES =
      `BCSM_TW'(64'(`BCSM_TERM_QUALIFY_MS) * 64'(`BCSM_CLK_HZ) / 64'd1000),
   parameter logic [`BCSM_TW-1:0] PREQUAL_CYCLES =
      `BCSM_TW'(64'(`BCSM_PREQUAL_S) * 64'(`BCSM_CLK_HZ)),
   parameter logic [`BCSM_TW-1:0] FASTCHARGE_CYCLES =
      `BCSM_TW'(64'(`BCSM_FASTCHARGE_S) * 64'(`BCSM_CLK_HZ)),
   parameter logic [`BCSM_TW-1:0] TOPOFF_CYCLES =
      `BCSM_TW'(64'(`BCSM_TOPOFF_S) * 64'(`BCSM_CLK_HZ)),
   parameter logic [`BCSM_TW-1:0] WATCHDOG_CYCLES =
      `BCSM_TW'(64'(`BCSM_WATCHDOG_S) * 64'(`BCSM_CLK_HZ))
) (
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [`BCSM_AW-1:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic [3:0] i_pstrb,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire logic i_input_valid,
   input wire logic i_vbat_below_precharge,
   input wire logic i_vbat_below_sysmin_margin,
   input wire logic i_vbat_at_regulation,
   input wire logic i_vbat_below_restart,
   input wire logic i_ichg_below_topoff,
   input wire logic i_thermal_shutdown,
   output logic [3:0] o_charge_detail_code,
   output logic o_charge_ok_flag,
   output logic o_charge_event_irq,
   output logic [1:0] o_current_select,
   output logic o_charging
);

   localparam int TM_SETTLE = 0;
   localparam int TM_PREQUAL = 1;
   localparam int TM_FAST = 2;
   localparam int TM_TOPOFF = 3;
   localparam int TM_TERM = 4;
   localparam int TM_WD = 5;
   localparam int TM_N = 6;

   bcsm_pkg::bcsm_main_t q;
   bcsm_pkg::bcsm_main_t d;

   logic [TM_N-1:0] tm_clear;
   logic [TM_N-1:0] tm_expired;
   logic [TM_N-1:0] tm_hit;
   logic [`BCSM_TW-1:0] tm_limit [TM_N];
   logic [`BCSM_TW-1:0] tm_count [TM_N];

   logic run_ok;
   logic wd_fire;
   logic in_prequal;
   logic in_fast;
   logic in_settle_state;
   logic state_change;
   logic st_update;
   logic st_force;
   logic st_force_irq;
   logic [3:0] st_code;
   logic st_ok;
   logic [3:0] sts_code;
   logic sts_ok;
   logic sts_irq;
   logic apb_access;
   logic apb_done;
   logic addr_mapped;
   logic [31:0] read_word;

   // detail code and ok flag that a state publishes
   function automatic logic [4:0] status_of(input bcsm_pkg::bcsm_state_t s);
      logic [4:0] r;
      r = {1'b0, `BCSM_CODE_IDLE};
      case (s)
         bcsm_pkg::ST_IDLE: r = {1'b1, `BCSM_CODE_IDLE};
         bcsm_pkg::ST_PRECHARGE: r = {1'b1, `BCSM_CODE_PRECHARGE};
         bcsm_pkg::ST_TRICKLE: r = {1'b1, `BCSM_CODE_TRICKLE};
         bcsm_pkg::ST_FAST_CC: r = {1'b1, `BCSM_CODE_FAST_CC};
         bcsm_pkg::ST_FAST_CV: r = {1'b1, `BCSM_CODE_FAST_CV};
         bcsm_pkg::ST_TOPOFF: r = {1'b1, `BCSM_CODE_TOPOFF};
         bcsm_pkg::ST_DONE: r = {1'b0, `BCSM_CODE_DONE};
         bcsm_pkg::ST_TIMER_FAULT: r = {1'b0, `BCSM_CODE_TIMER_FAULT};
         bcsm_pkg::ST_WD_SUSPEND: r = {1'b0, `BCSM_CODE_WD_SUSPEND};
         bcsm_pkg::ST_THERMAL: r = {1'b0, `BCSM_CODE_THERMAL};
         default: r = {1'b0, `BCSM_CODE_IDLE};
      endcase
      return r;
   endfunction

   // state groups used by the timers and the watchdog
   assign in_prequal = (q.state == bcsm_pkg::ST_PRECHARGE) || (q.state == bcsm_pkg::ST_TRICKLE);
   assign in_fast = (q.state == bcsm_pkg::ST_FAST_CC) || (q.state == bcsm_pkg::ST_FAST_CV) ||
                    (q.state == bcsm_pkg::ST_TOPOFF);
   assign in_settle_state = in_prequal || in_fast || (q.state == bcsm_pkg::ST_IDLE) ||
                            (q.state == bcsm_pkg::ST_DONE);
   assign run_ok = q.charge_en && i_input_valid;
   assign wd_fire = q.wd_en && tm_expired[TM_WD] &&
                    (in_prequal || in_fast || (q.state == bcsm_pkg::ST_DONE));
   assign state_change = (d.state != q.state);

   // timer clears; idle holds every safety timer and the watchdog at zero
   assign tm_clear[TM_SETTLE] = state_change;
   assign tm_clear[TM_PREQUAL] = !in_prequal;
   assign tm_clear[TM_FAST] = !in_fast;
   assign tm_clear[TM_TOPOFF] = (q.state != bcsm_pkg::ST_TOPOFF);
   assign tm_clear[TM_TERM] = (q.state != bcsm_pkg::ST_FAST_CV) || !i_ichg_below_topoff;
   assign tm_clear[TM_WD] = (q.state == bcsm_pkg::ST_IDLE) || q.wd_clear || !q.wd_en;

   assign tm_limit[TM_SETTLE] = SETTLE_CYCLES;
   assign tm_limit[TM_PREQUAL] = PREQUAL_CYCLES;
   assign tm_limit[TM_FAST] = FASTCHARGE_CYCLES;
   assign tm_limit[TM_TOPOFF] = TOPOFF_CYCLES;
   assign tm_limit[TM_TERM] = TERM_QUALIFY_CYCLES;
   assign tm_limit[TM_WD] = WATCHDOG_CYCLES;

   // one counter per timer
   generate
      for (genvar g = 0; g < TM_N; g++) begin : g_tm
         bcsm_timer u_timer (
            .i_clock(i_clock),
            .i_rst(i_rst),
            .i_clear(tm_clear[g]),
            .i_limit(tm_limit[g]),
            .o_expired(tm_expired[g]),
            .o_hit(tm_hit[g]),
            .o_count(tm_count[g])
         );
      end
   endgenerate

   // settled states publish after the delay; fault states publish on entry
   assign st_update = tm_hit[TM_SETTLE] && in_settle_state;
   assign st_force = state_change && ((d.state == bcsm_pkg::ST_TIMER_FAULT) ||
                     (d.state == bcsm_pkg::ST_WD_SUSPEND) || (d.state == bcsm_pkg::ST_THERMAL));
   assign st_force_irq = state_change && (d.state == bcsm_pkg::ST_TIMER_FAULT);
   assign {st_ok, st_code} = st_force ? status_of(d.state) : status_of(q.state);

   bcsm_status u_status (
      .i_clock(i_clock),
      .i_rst(i_rst),
      .i_update(st_update),
      .i_force(st_force),
      .i_force_irq(st_force_irq),
      .i_code(st_code),
      .i_ok(st_ok),
      .o_code(sts_code),
      .o_ok(sts_ok),
      .o_irq(sts_irq)
   );

   // apb decode; one wait state keeps pready and prdata registered
   assign apb_access = i_psel && i_penable;
   assign apb_done = apb_access && q.pready;
   assign addr_mapped = (i_paddr == `BCSM_OFS_CTRL) || (i_paddr == `BCSM_OFS_WDCLR) ||
                        (i_paddr == `BCSM_OFS_STATUS);

   // read mux; the clear register reads back as zero
   always_comb begin
      read_word = 32'h0000_0000;
      case (i_paddr)
         `BCSM_OFS_CTRL: begin
            read_word[`BCSM_CTRL_EN_BIT] = q.charge_en;
            read_word[`BCSM_CTRL_PQ_BIT] = q.prequal_en;
            read_word[`BCSM_CTRL_WD_BIT] = q.wd_en;
         end
         `BCSM_OFS_STATUS: begin
            read_word[`BCSM_STAT_CODE_LSB +: 4] = sts_code;
            read_word[`BCSM_STAT_OK_BIT] = sts_ok;
            read_word[`BCSM_STAT_STATE_LSB +: 4] = q.state;
            read_word[`BCSM_STAT_WDEXP_BIT] = tm_expired[TM_WD];
         end
         default: read_word = 32'h0000_0000;
      endcase
   end

   // bus, configuration and charge state machine
   always_comb begin
      d = q;
      d.wd_clear = 1'b0;
      d.pready = apb_access && !q.pready;
      if (apb_access && !q.pready) begin
         d.prdata = addr_mapped ? read_word : 32'h0000_0000;
         d.pslverr = !addr_mapped;
      end
      if (apb_done && i_pwrite && i_pstrb[0]) begin
         if (i_paddr == `BCSM_OFS_CTRL) begin
            d.charge_en = i_pwdata[`BCSM_CTRL_EN_BIT];
            d.prequal_en = i_pwdata[`BCSM_CTRL_PQ_BIT];
            d.wd_en = i_pwdata[`BCSM_CTRL_WD_BIT];
         end
         if ((i_paddr == `BCSM_OFS_WDCLR) &&
             (i_pwdata[`BCSM_WDCLR_MSB:0] == `BCSM_WDCLR_RESTART)) begin
            d.wd_clear = 1'b1;
         end
      end
      // thermal shutdown outranks everything, then the idle conditions
      if (i_thermal_shutdown) begin
         d.state = bcsm_pkg::ST_THERMAL;
      end else if (q.state == bcsm_pkg::ST_THERMAL) begin
         d.state = bcsm_pkg::ST_IDLE;
      end else if (!run_ok) begin
         d.state = bcsm_pkg::ST_IDLE;
      end else if (wd_fire) begin
         d.state = bcsm_pkg::ST_WD_SUSPEND;
      end else begin
         case (q.state)
            bcsm_pkg::ST_IDLE: begin
               // reaching here means input valid and enabled together
               if (i_vbat_below_precharge) begin
                  d.state = bcsm_pkg::ST_PRECHARGE;
               end else if (i_vbat_below_sysmin_margin && q.prequal_en) begin
                  d.state = bcsm_pkg::ST_TRICKLE;
               end else begin
                  d.state = bcsm_pkg::ST_FAST_CC;
               end
            end
            bcsm_pkg::ST_PRECHARGE: begin
               if (tm_expired[TM_PREQUAL]) begin
                  d.state = bcsm_pkg::ST_TIMER_FAULT;
               end else if (!i_vbat_below_precharge) begin
                  d.state = q.prequal_en ? bcsm_pkg::ST_TRICKLE : bcsm_pkg::ST_FAST_CC;
               end
            end
            bcsm_pkg::ST_TRICKLE: begin
               if (tm_expired[TM_PREQUAL]) begin
                  d.state = bcsm_pkg::ST_TIMER_FAULT;
               end else if (!i_vbat_below_sysmin_margin || !q.prequal_en) begin
                  d.state = bcsm_pkg::ST_FAST_CC;
               end
            end
            bcsm_pkg::ST_FAST_CC: begin
               if (tm_expired[TM_FAST]) begin
                  d.state = bcsm_pkg::ST_TIMER_FAULT;
               end else if (i_vbat_at_regulation) begin
                  d.state = bcsm_pkg::ST_FAST_CV;
               end
            end
            bcsm_pkg::ST_FAST_CV: begin
               if (tm_expired[TM_FAST]) begin
                  d.state = bcsm_pkg::ST_TIMER_FAULT;
               end else if (tm_expired[TM_TERM]) begin
                  d.state = bcsm_pkg::ST_TOPOFF;
               end
            end
            bcsm_pkg::ST_TOPOFF: begin
               // restart wins over done when both arrive together
               if (i_vbat_below_restart) begin
                  d.state = bcsm_pkg::ST_FAST_CC;
               end else if (tm_expired[TM_TOPOFF]) begin
                  d.state = bcsm_pkg::ST_DONE;
               end
            end
            bcsm_pkg::ST_DONE: begin
               if (i_vbat_below_restart) begin
                  d.state = bcsm_pkg::ST_FAST_CC;
               end
            end
            bcsm_pkg::ST_TIMER_FAULT: begin
               d.state = bcsm_pkg::ST_TIMER_FAULT; // leaves only via disable, input loss or thermal shutdown
            end
            bcsm_pkg::ST_WD_SUSPEND: begin
               if (q.wd_clear) begin
                  d.state = bcsm_pkg::ST_IDLE;
               end
            end
            default: d.state = bcsm_pkg::ST_IDLE;
         endcase
      end
      // current request follows the next state so it lines up with it
      case (d.state)
         bcsm_pkg::ST_PRECHARGE: d.current_sel = `BCSM_ISEL_PRECHARGE;
         bcsm_pkg::ST_TRICKLE: d.current_sel = `BCSM_ISEL_TRICKLE;
         bcsm_pkg::ST_FAST_CC: d.current_sel = `BCSM_ISEL_FAST;
         bcsm_pkg::ST_FAST_CV: d.current_sel = `BCSM_ISEL_FAST;
         bcsm_pkg::ST_TOPOFF: d.current_sel = `BCSM_ISEL_FAST;
         default: d.current_sel = `BCSM_ISEL_OFF;
      endcase
      d.charging = (d.current_sel != `BCSM_ISEL_OFF);
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         q <= '{state: bcsm_pkg::ST_IDLE, charge_en: `BCSM_RST_CHARGE_EN,
                prequal_en: `BCSM_RST_PREQUAL_EN, wd_en: `BCSM_RST_WD_EN,
                wd_clear: 1'b0, current_sel: `BCSM_ISEL_OFF, charging: 1'b0,
                prdata: 32'h0000_0000, pready: 1'b0, pslverr: 1'b0};
      end else begin
         q <= d;
      end
   end

   assign o_prdata = q.prdata;
   assign o_pready = q.pready;
   assign o_pslverr = q.pslverr;
   assign o_charge_detail_code = sts_code;
   assign o_charge_ok_flag = sts_ok;
   assign o_charge_event_irq = sts_irq;
   assign o_current_select = q.current_sel;
   assign o_charging = q.charging;

   // checks on the state machine and its status outputs
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_rst);

   a_idle_forced: assert property (
      (!run_ok && !i_thermal_shutdown && q.state != bcsm_pkg::ST_THERMAL)
      |=> q.state == bcsm_pkg::ST_IDLE)
      else $error("disable or bad input did not force idle");

   a_idle_settle: assert property (
      (tm_hit[TM_SETTLE] && q.state == bcsm_pkg::ST_IDLE)
      |=> o_charge_detail_code == 4'h8 && o_charge_ok_flag && (o_charge_event_irq == !$past(sts_ok)))
      else $error("idle status after settle is wrong");

   a_idle_quiet: assert property (
      (q.state == bcsm_pkg::ST_IDLE) [*2]
      |-> o_current_select == 2'h0 && tm_count[TM_WD] == '0 && tm_count[TM_PREQUAL] == '0
          && tm_count[TM_FAST] == '0)
      else $error("idle left current or timers active");

   a_idle_exit: assert property (
      (q.state == bcsm_pkg::ST_IDLE) ##1 (q.state != bcsm_pkg::ST_IDLE
         && q.state != bcsm_pkg::ST_THERMAL)
      |-> $past(run_ok))
      else $error("idle left without valid input and enable");

   a_prequal_fault: assert property (
      (in_prequal && tm_expired[TM_PREQUAL] && run_ok && !wd_fire && !i_thermal_shutdown)
      |=> q.state == bcsm_pkg::ST_TIMER_FAULT)
      else $error("prequal timeout did not fault");

   a_trickle_bypass: assert property (
      (q.state == bcsm_pkg::ST_TRICKLE && !q.prequal_en && !tm_expired[TM_PREQUAL] && run_ok
       && !wd_fire && !i_thermal_shutdown)
      |=> q.state == bcsm_pkg::ST_FAST_CC && o_current_select == 2'h3)
      else $error("cleared prequal enable did not bypass trickle");

   a_cc_to_cv: assert property (
      (q.state == bcsm_pkg::ST_FAST_CC && i_vbat_at_regulation && !tm_expired[TM_FAST]
       && run_ok && !wd_fire && !i_thermal_shutdown)
      |=> q.state == bcsm_pkg::ST_FAST_CV)
      else $error("regulation did not move cc to cv");

   a_topoff_entry: assert property (
      (q.state != bcsm_pkg::ST_TOPOFF) ##1 (q.state == bcsm_pkg::ST_TOPOFF)
      |-> $past(q.state) == bcsm_pkg::ST_FAST_CV)
      else $error("topoff entered from a state other than cv");

   a_restart_cc: assert property (
      (q.state == bcsm_pkg::ST_TOPOFF && i_vbat_below_restart && run_ok && !wd_fire
       && !i_thermal_shutdown)
      |=> q.state == bcsm_pkg::ST_FAST_CC)
      else $error("restart level did not return to cc");

   a_wd_suspend: assert property (
      (wd_fire && run_ok && !i_thermal_shutdown)
      |=> q.state == bcsm_pkg::ST_WD_SUSPEND && !o_charging)
      else $error("watchdog expiry did not suspend charging");

   a_fault_entry: assert property (
      $rose(q.state == bcsm_pkg::ST_TIMER_FAULT)
      |-> o_charge_event_irq && !o_charge_ok_flag && o_charge_detail_code == 4'h6)
      else $error("timer fault status not published on entry");

endmodule

`default_nettype wire

// File: tb/bcsm_battery.sv
`timescale 1ns/10ps
`default_nettype none
// comparator bank of the battery side: 0 deep, 1 trickle band, 2 fast band, 3 at regulation
module bcsm_battery (
   input wire logic [1:0] i_level,
   output logic o_below_precharge,
   output logic o_below_sysmin_margin,
   output logic o_at_regulation,
   output logic o_below_restart
);
   // levels are ordered so each threshold is a simple compare
   assign o_below_precharge = (i_level == 2'h0);
   assign o_below_sysmin_margin = (i_level <= 2'h1);
   assign o_at_regulation = (i_level == 2'h3);
   // restart level sits below regulation, so only level 3 is above it
   assign o_below_restart = (i_level <= 2'h2);
endmodule
`default_nettype wire

// File: tb/bcsm_charger_test.sv
`timescale 1ns/10ps
`default_nettype none
module bcsm_charger_test;
   logic i_clock = 1'b0;
   logic i_rst = 1'b1;
   logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, valid = 1'b0, ibelow = 1'b0, err;
   logic therm = 1'b0;
   logic [3:0] strb = 4'hf;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwd = 32'h0000_0000, rd, prdata;
   logic [1:0] level = 2'h0, cur;
   logic [3:0] code;
   logic pready, pslverr, ok, irq, chg, b_pre, b_sys, b_reg, b_rst;
   int n_mismatch = 0, checks_done = 0, n_irq = 0, nb;

   always #12.5 i_clock = ~i_clock;
   // count event pulses; each one stands for a single cycle
   always @(posedge i_clock) if (irq === 1'b1) n_irq++;

   bcsm_battery bat_u (.i_level(level), .o_below_precharge(b_pre),
      .o_below_sysmin_margin(b_sys), .o_at_regulation(b_reg), .o_below_restart(b_rst));

   // short timers keep the run small; settle stays below every other count but the term qualify one
   localparam logic [39:0] T_SETTLE = 40'h00_0000_0008;
   localparam logic [39:0] T_TERM = 40'h00_0000_0004;
   localparam logic [39:0] T_PREQUAL = 40'h00_0000_00c8;
   localparam logic [39:0] T_FAST = 40'h00_0000_0190;
   localparam logic [39:0] T_TOPOFF = 40'h00_0000_0064;
   localparam logic [39:0] T_WD = 40'h00_0000_012c;
   bcsm_charger #(.SETTLE_CYCLES(T_SETTLE), .TERM_QUALIFY_CYCLES(T_TERM),
      .PREQUAL_CYCLES(T_PREQUAL), .FASTCHARGE_CYCLES(T_FAST),
      .TOPOFF_CYCLES(T_TOPOFF), .WATCHDOG_CYCLES(T_WD)) dut_u (
      .i_clock(i_clock), .i_rst(i_rst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
      .i_paddr(paddr), .i_pwdata(pwd), .i_pstrb(strb), .o_prdata(prdata),
      .o_pready(pready), .o_pslverr(pslverr), .i_input_valid(valid),
      .i_vbat_below_precharge(b_pre), .i_vbat_below_sysmin_margin(b_sys),
      .i_vbat_at_regulation(b_reg), .i_vbat_below_restart(b_rst),
      .i_ichg_below_topoff(ibelow), .i_thermal_shutdown(therm),
      .o_charge_detail_code(code), .o_charge_ok_flag(ok), .o_charge_event_irq(irq),
      .o_current_select(cur), .o_charging(chg));

   task check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h want %h", $time, seen, exp);
      end
   endtask

   // one apb transfer; the request holds until pready is seen high
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge i_clock);
      psel <= 1'b1; pwr <= w; paddr <= a; pwd <= d; pen <= 1'b0;
      @(posedge i_clock);
      pen <= 1'b1;
      do @(posedge i_clock); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask

   // wait for a published code and flag; reset already shows the idle code with ok low
   task wait_code(input logic [3:0] e, input logic [2:0] c, input logic k);
      for (int i = 0; i < 2000 && (code !== e || ok !== k); i++) @(posedge i_clock);
      @(negedge i_clock);
      check(code, e);
      check(ok, k);
      if (c[2] === 1'b0) check(cur, c[1:0]);
      check(chg, (c[1:0] != 2'h0) && !c[2] ? 1'b1 : (c[2] ? chg : 1'b0));
      // hand back on a rising edge so the next stimulus lands there
      @(posedge i_clock);
   endtask

   task finish_test;
      $display("mismatches %0d checks %0d", n_mismatch, checks_done);
      if (n_mismatch == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   initial begin
      repeat (6) @(posedge i_clock);
      i_rst <= 1'b0;
      wait_code(4'h8, 3'h0, 1'b1);
      check(n_irq, 1);
      valid <= 1'b1;
      wait_code(4'h0, 3'h1, 1'b1);
      nb = n_irq;
      wait_code(4'h6, 3'h0, 1'b0);
      check(n_irq, nb + 1);
      apb(1'b1, 12'h000, 32'h0000_0000);
      wait_code(4'h8, 3'h0, 1'b1);
      apb(1'b0, 12'h008, 32'h0000_0000);
      check(rd[12:0], 32'h0000_0018);
      level <= 2'h1;
      apb(1'b1, 12'h000, 32'h0000_0003);
      wait_code(4'h0, 3'h2, 1'b1);
      level <= 2'h2;
      wait_code(4'h1, 3'h3, 1'b1);
      level <= 2'h3;
      wait_code(4'h2, 3'h3, 1'b1);
      ibelow <= 1'b1;
      wait_code(4'h3, 3'h3, 1'b1);
      wait_code(4'h4, 3'h0, 1'b0);
      ibelow <= 1'b0;
      level <= 2'h2;
      wait_code(4'h1, 3'h3, 1'b1);
      apb(1'b1, 12'h000, 32'h0000_0000);
      wait_code(4'h8, 3'h0, 1'b1);
      level <= 2'h1;
      apb(1'b1, 12'h000, 32'h0000_0001);
      wait_code(4'h1, 3'h3, 1'b1);
      apb(1'b1, 12'h000, 32'h0000_0005);
      wait_code(4'hb, 3'h0, 1'b0);
      apb(1'b1, 12'h004, 32'h0000_0001);
      wait_code(4'h1, 3'h3, 1'b1);
      // thermal shutdown outranks a disable; dropping it returns to idle
      therm <= 1'b1;
      wait_code(4'ha, 3'h0, 1'b0);
      apb(1'b1, 12'h000, 32'h0000_0000);
      apb(1'b0, 12'h008, 32'h0000_0000);
      check(rd[12:0], 32'h0000_090a);
      therm <= 1'b0;
      wait_code(4'h8, 3'h0, 1'b1);
      // a write without byte lane 0 must leave control untouched
      strb <= 4'h0;
      apb(1'b1, 12'h000, 32'h0000_0001);
      strb <= 4'hf;
      apb(1'b0, 12'h000, 32'h0000_0000);
      check(rd, 32'h0000_0000);
      apb(1'b0, 12'h0fc, 32'h0000_0000);
      check(err, 1'b1);
      finish_test;
   end

   // the whole sequence needs under a thousand cycles
   initial begin
      #500000;
      n_mismatch++;
      finish_test;
   end
endmodule
`default_nettype wire
